/* File: hw/poc_pkg.sv */
package poc_pkg;

  // bus geometry
  localparam int unsigned POC_ADDR_W = 4; // byte address inside the block
  localparam int unsigned POC_DATA_W = 32; // avalon data width
  localparam int unsigned POC_PHASES = 6; // pwm output pins under guard
  localparam int unsigned POC_CMP_NUM = 2; // lower and upper comparator

  // comparator index
  localparam int unsigned POC_CMP_LOWER = 0; // first comparator, lower reference
  localparam int unsigned POC_CMP_UPPER = 1; // second comparator, upper reference

  // register byte offsets
  localparam logic [3:0] POC_OFS_MODE = 4'h0; // option_unit_mode_reg
  localparam logic [3:0] POC_OFS_TRIG = 4'h4; // software trigger register, write only
  localparam logic [3:0] POC_OFS_STAT = 4'h8; // status register, read only

  // option_unit_mode_reg fields
  localparam int unsigned POC_MODE_DET_BIT = 0; // detect_mode_select

  // trigger register fields
  localparam int unsigned POC_TRIG_START_BIT = 0; // sw_start_trigger
  localparam int unsigned POC_TRIG_STOP_BIT = 1; // sw_stop_trigger

  // status register fields
  localparam int unsigned POC_STAT_HIZ_BIT = 0; // pins held in high impedance
  localparam int unsigned POC_STAT_UPPER_BIT = 1; // upper threshold tripped in two-stage
  localparam int unsigned POC_STAT_STOP_BIT = 2; // stop trigger accepted
  localparam int unsigned POC_STAT_PEND_BIT = 3; // release waits for the period
  localparam int unsigned POC_STAT_ARMED_BIT = 4; // unit started
  localparam int unsigned POC_STAT_LOWER_LVL_BIT = 5; // first comparator level
  localparam int unsigned POC_STAT_UPPER_LVL_BIT = 6; // second comparator level
  localparam int unsigned POC_STAT_PWM_MODE_BIT = 7; // timer in a pwm-type mode

  // detection modes
  localparam logic POC_MODE_TWO_STAGE = 1'h0; // two-stage overcurrent
  localparam logic POC_MODE_INDUCED = 1'h1; // overcurrent and induced current

  // reset values
  localparam logic POC_MODE_RESET = POC_MODE_TWO_STAGE; // mode after reset
  localparam logic [31:0] POC_RDATA_RESET = 32'h0000_0000; // read data after reset
  localparam logic [5:0] POC_PINS_RESET = 6'h00; // pin outputs after reset

  // state of the edge detector
  typedef struct packed {
    logic prev; // level seen one cycle ago
  } poc_edge_state_t;

endpackage

/* File: hw/poc_cmp_edge.sv */
`timescale 1ns/1ps

// edge detector for one comparator output; inputs arrive synchronous
module poc_cmp_edge
  import poc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // comparator side
  input wire logic level_in,
  // detected events
  output logic rise,
  output logic fall
);

  poc_edge_state_t st; // registered state
  poc_edge_state_t next_st; // next state

  // edges compare the live level with last cycle
  assign rise = level_in & ~st.prev;
  assign fall = ~level_in & st.prev;

  // next state: remember the level
  always_comb begin
    next_st = st;
    next_st.prev = level_in;
  end

  // reset to low so a comparator high out of reset counts as a rise
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule // poc_cmp_edge

/* File: hw/poc_cutoff.sv */
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps

// Function
// - two-stage: lower trip forces six pins hi-z
// - lower-only trip releases at next period
// - upper trip releases after stop write, period
// - upper trip hold survives comparator falling edges
// - trips detected on comparator rising edges
// - induced mode: either comparator trip gives hi-z
// - induced mode: in-window input auto releases, period
// - mode bit selects two-stage or induced
// - start trigger both modes, stop two-stage only
// - protection only while timer in pwm mode
module poc_cutoff
  import poc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // comparators
  input wire logic cmp_lower_in,
  input wire logic cmp_upper_in,
  // pwm timer
  input wire logic timer_period,
  input wire logic timer_pwm_mode,
  input wire logic [5:0] timer_pwm_in,
  input wire logic [5:0] timer_pwm_oe,
  // pwm pins
  output logic [5:0] pwm_out,
  output logic [5:0] pwm_oe
);

  // all registered state of the block except the edge detector flops
  typedef struct packed {
    logic mode; // detect_mode_select
    logic armed; // started by sw_start_trigger
    logic hiz; // pins cut off
    logic upper; // upper threshold seen during this cutoff in two-stage
    logic stop_req; // stop trigger accepted
    logic pending; // release condition met, waiting for period
    logic waitreq; // avalon waitrequest
    logic [31:0] rdata; // avalon read data
    logic [5:0] pins; // pin levels
    logic [5:0] oe; // pin enables
  } poc_state_t;

  poc_state_t st; // registered state
  poc_state_t next_st; // next state

  logic [1:0] cmp_level; // comparator levels
  logic [1:0] cmp_rise; // comparator rising edges
  logic bus_req; // read or write present
  logic bus_fire; // access completes this edge
  logic mode_wr; // write to option_unit_mode_reg
  logic trig_wr; // write to trigger register
  logic start_wr; // start trigger written
  logic stop_wr; // stop trigger written
  logic active; // protection live
  logic trip; // a comparator rose while live
  logic release_cond; // levels allow a release

  assign cmp_level = {cmp_upper_in, cmp_lower_in};

  // one edge detector per comparator
  genvar gi;
  generate
    for (gi = 0; gi < POC_CMP_NUM; gi++) begin : g_edge
      poc_cmp_edge u_edge (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .level_in(cmp_level[gi]),
        .rise(cmp_rise[gi]),
        .fall()
      );
    end
  endgenerate

  // register decode, used for both reads and writes
  function automatic logic is_reg(input logic [3:0] addr, input logic [3:0] ofs);
    is_reg = (addr == ofs);
  endfunction

  // bus qualifiers: an access completes at the edge with waitrequest low
  // one fixed wait cycle lets read data leave a flop, at the cost of a cycle per access
  assign bus_req = avs_read | avs_write;
  assign bus_fire = bus_req & ~st.waitreq;
  assign mode_wr = avs_write & bus_fire & is_reg(avs_address, POC_OFS_MODE);
  assign trig_wr = avs_write & bus_fire & is_reg(avs_address, POC_OFS_TRIG);
  assign start_wr = trig_wr & avs_writedata[POC_TRIG_START_BIT];
  assign stop_wr = trig_wr & avs_writedata[POC_TRIG_STOP_BIT];

  // protection acts only when started and timer in a pwm-type mode
  assign active = st.armed & timer_pwm_mode & ~mode_wr;
  // trips are edge detected on either comparator
  assign trip = active & (cmp_rise[POC_CMP_LOWER] | cmp_rise[POC_CMP_UPPER]);

  // both comparators low; after an upper trip in two-stage also need stop
  assign release_cond = ~cmp_level[POC_CMP_LOWER] & ~cmp_level[POC_CMP_UPPER] &
                        (st.mode | ~st.upper | st.stop_req);

  // next state
  always_comb begin
    next_st = st;
    // bus handshake: one wait cycle, then a single ready cycle
    if (bus_req && st.waitreq) begin
      next_st.waitreq = 1'h0;
      next_st.rdata = POC_RDATA_RESET;
      // read data prepared now, stands at the completing edge
      if (avs_read) begin
        if (is_reg(avs_address, POC_OFS_MODE)) begin
          next_st.rdata[POC_MODE_DET_BIT] = st.mode;
        end else if (is_reg(avs_address, POC_OFS_STAT)) begin
          next_st.rdata[POC_STAT_HIZ_BIT] = st.hiz;
          next_st.rdata[POC_STAT_UPPER_BIT] = st.upper;
          next_st.rdata[POC_STAT_STOP_BIT] = st.stop_req;
          next_st.rdata[POC_STAT_PEND_BIT] = st.pending;
          next_st.rdata[POC_STAT_ARMED_BIT] = st.armed;
          next_st.rdata[POC_STAT_LOWER_LVL_BIT] = cmp_level[POC_CMP_LOWER];
          next_st.rdata[POC_STAT_UPPER_LVL_BIT] = cmp_level[POC_CMP_UPPER];
          next_st.rdata[POC_STAT_PWM_MODE_BIT] = timer_pwm_mode;
        end else begin
          // trigger register and unmapped addresses read zero
          next_st.rdata = POC_RDATA_RESET;
        end
      end
    end else begin
      next_st.waitreq = 1'h1;
    end

    // mode write stops the unit; reuse needs the whole sequence again
    if (mode_wr) begin
      next_st.mode = avs_writedata[POC_MODE_DET_BIT];
      next_st.armed = 1'h0;
      next_st.hiz = 1'h0;
      next_st.upper = 1'h0;
      next_st.stop_req = 1'h0;
      next_st.pending = 1'h0;
    end

    // start trigger honoured in both modes
    if (start_wr) begin
      next_st.armed = 1'h1;
    end

    // stop trigger only counts in two-stage after an upper trip
    if (stop_wr && (st.mode == POC_MODE_TWO_STAGE) && st.upper && st.hiz) begin
      next_st.stop_req = 1'h1;
    end

    // latch a release request once the levels permit it
    if (st.hiz && release_cond && !trip) begin
      next_st.pending = 1'h1;
    end

    // release only on the carrier period event
    if (st.pending && timer_period && release_cond && !trip) begin
      next_st.hiz = 1'h0;
      next_st.upper = 1'h0;
      next_st.stop_req = 1'h0;
      next_st.pending = 1'h0;
    end

    // a new trip wins over any release in the same cycle
    if (trip) begin
      next_st.hiz = 1'h1;
      next_st.pending = 1'h0;
      next_st.stop_req = 1'h0;
      // upper trip in two-stage keeps hold until stop trigger
      if (cmp_rise[POC_CMP_UPPER] && (st.mode == POC_MODE_TWO_STAGE)) begin
        next_st.upper = 1'h1;
      end
    end

    // outside pwm-type modes the cutoff does not act
    if (!timer_pwm_mode) begin
      next_st.hiz = 1'h0;
      next_st.pending = 1'h0;
    end

    // pins: registered pass-through, enables dropped together with hiz
    next_st.pins = timer_pwm_in;
    next_st.oe = timer_pwm_oe & {POC_PHASES{~next_st.hiz}};
  end

  // state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st.mode <= POC_MODE_RESET;
      st.armed <= 1'h0;
      st.hiz <= 1'h0;
      st.upper <= 1'h0;
      st.stop_req <= 1'h0;
      st.pending <= 1'h0;
      st.waitreq <= 1'h1;
      st.rdata <= POC_RDATA_RESET;
      st.pins <= POC_PINS_RESET;
      st.oe <= POC_PINS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = st.waitreq;
  assign pwm_out = st.pins;
  assign pwm_oe = st.oe;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  // any live rising edge cuts all six enables next cycle
  a_trip_cuts_pins: assert property (
    trip |=> (st.hiz && (pwm_oe == 6'h00)))
    else $error("trip did not cut pwm pins");

  // upper trip in two-stage is remembered
  a_upper_trip_latch: assert property (
    trip && cmp_rise[POC_CMP_UPPER] && (st.mode == POC_MODE_TWO_STAGE) |=> st.upper)
    else $error("upper trip not latched");

  // upper hold persists without an accepted stop trigger
  a_upper_hold_kept: assert property (
    st.hiz && st.upper && !st.stop_req && !stop_wr && !mode_wr && timer_pwm_mode |=> st.hiz)
    else $error("upper trip hold released without stop");

  // no release between period events
  a_period_sync_only: assert property (
    st.hiz && !timer_period && !mode_wr && timer_pwm_mode |=> st.hiz)
    else $error("hiz released off the period event");

  // lower-only trip releases on the first usable period
  a_lower_auto_release: assert property (
    st.pending && !st.upper && timer_period && release_cond && !trip && timer_pwm_mode |=> !st.hiz)
    else $error("lower trip not auto released");

  // induced mode releases once back inside the window
  a_induced_release: assert property (
    (st.mode == POC_MODE_INDUCED) && st.pending && timer_period && release_cond && !trip && timer_pwm_mode
    |=> !st.hiz)
    else $error("induced mode not auto released");

  // stop trigger ignored in induced mode
  a_stop_ignored: assert property (
    stop_wr && (st.mode == POC_MODE_INDUCED) && !st.stop_req |=> !st.stop_req)
    else $error("stop trigger accepted in induced mode");

  // start trigger arms in either mode
  a_start_arms: assert property (
    start_wr |=> st.armed)
    else $error("start trigger did not arm");

  // mode bit follows the written value
  a_mode_select: assert property (
    mode_wr |=> (st.mode == $past(avs_writedata[POC_MODE_DET_BIT])) && !st.armed)
    else $error("mode bit not taken");

  // no cutoff outside pwm-type timer modes
  a_pwm_mode_gate: assert property (
    !timer_pwm_mode |=> !st.hiz)
    else $error("cutoff active outside pwm mode");

  // bus answers one cycle after the request appears
  a_bus_answer: assert property (
    bus_req && st.waitreq |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

  // cut pins never drive while hiz is held
  a_hiz_no_drive: assert property (
    st.hiz |-> (pwm_oe == 6'h00))
    else $error("pwm pins driven during cutoff");

  // a stop without an upper trip is refused
  a_stop_needs_upper: assert property (
    stop_wr && !st.upper && !st.stop_req |=> !st.stop_req)
    else $error("stop trigger accepted without upper trip");

  // an unarmed unit never starts a cutoff
  a_unarmed_quiet: assert property (
    !st.armed && !st.hiz |=> !st.hiz)
    else $error("cutoff started while unarmed");

  // main scenarios
  c_upper_stop_release: cover property (st.upper && st.stop_req ##[1:50] !st.hiz);
  c_lower_auto_release: cover property (st.hiz && !st.upper ##[1:50] !st.hiz);
  c_induced_trip: cover property ((st.mode == POC_MODE_INDUCED) && trip);
  c_stop_ignored: cover property (stop_wr && (st.mode == POC_MODE_INDUCED));

endmodule // poc_cutoff

/* File: bench/poc_far_side.sv */
`timescale 1ns/1ps

// two comparators on one monitored level plus a free-running pwm timer
module poc_far_side
  import poc_pkg::*;
#(
  parameter logic [7:0] REF_LO = 8'h40, // lower reference
  parameter logic [7:0] REF_HI = 8'hc0, // upper reference, kept above lower
  parameter logic [7:0] LAST = 8'h07 // carrier period minus one
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // analog side
  input wire logic [7:0] level,
  input wire logic invert_lower,
  // comparator outputs
  output logic cmp_lower_in,
  output logic cmp_upper_in,
  // timer outputs
  output logic timer_period,
  output logic [5:0] timer_pwm_in,
  output logic [5:0] timer_pwm_oe
);
  logic [7:0] count; // carrier counter

  // comparators and timer, all registered like the real synchronous sources
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmp_lower_in <= 1'b0;
      cmp_upper_in <= 1'b0;
      count <= 8'h00;
      timer_period <= 1'b0;
      timer_pwm_in <= 6'h00;
    end else begin
      // same level feeds both, inverted lower output in induced mode
      cmp_lower_in <= (level > REF_LO) ^ invert_lower;
      cmp_upper_in <= level > REF_HI;
      count <= (count == LAST) ? 8'h00 : count + 8'h01;
      timer_period <= count == LAST;
      // pattern changes every cycle so a stale pin copy shows
      timer_pwm_in <= count[5:0] ^ 6'h2a;
    end
  end

  // all phases driven; no external-pin cutoff path exists here
  assign timer_pwm_oe = 6'h3f;
endmodule // poc_far_side

/* File: bench/pwm_overcurrent_cutoff_tb.sv */
`timescale 1ns/1ps

module pwm_overcurrent_cutoff_tb
  import poc_pkg::*;
;
  // one row: mode, quiet level, trip level, auto release expected
  typedef struct packed {
    logic mode;
    logic [7:0] idle;
    logic [7:0] trip;
    logic rel;
  } poc_row_t;
  poc_row_t rows [4] = '{'{1'b0, 8'h00, 8'h80, 1'b1}, '{1'b0, 8'h00, 8'hff, 1'b0},
    '{1'b1, 8'h80, 8'hff, 1'b1}, '{1'b1, 8'h80, 8'h00, 1'b1}};
  logic ref_clk, resetn, avs_read, avs_write, avs_waitrequest, cmp_lower_in, cmp_upper_in;
  logic timer_period, timer_pwm_mode, inv;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [5:0] timer_pwm_in, timer_pwm_oe, pwm_out, pwm_oe, v;
  logic [7:0] level;
  int num_errors = 0;
  int num_checks = 0;

  poc_cutoff DUT (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmp_lower_in(cmp_lower_in), .cmp_upper_in(cmp_upper_in),
    .timer_period(timer_period), .timer_pwm_mode(timer_pwm_mode), .timer_pwm_in(timer_pwm_in),
    .timer_pwm_oe(timer_pwm_oe), .pwm_out(pwm_out), .pwm_oe(pwm_oe));
  poc_far_side far (.ref_clk(ref_clk), .resetn(resetn), .level(level), .invert_lower(inv),
    .cmp_lower_in(cmp_lower_in), .cmp_upper_in(cmp_upper_in), .timer_period(timer_period),
    .timer_pwm_in(timer_pwm_in), .timer_pwm_oe(timer_pwm_oe));

  // 250 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // verdict and end of run
  task automatic results();
    if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= we;
    avs_read <= !we;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    chk(n, 32'd2); // one wait cycle, then the answer edge
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  // mode write then start, the full sequence every time
  task automatic arm(input logic m);
    bus(1'b1, POC_OFS_MODE, {31'h0, m}, rd);
    bus(1'b1, POC_OFS_TRIG, 32'h1, rd);
    wait_cyc(3);
  endtask

  // hang guard, far above the few hundred cycles needed
  initial begin
    #40000;
    num_errors++;
    results();
  end

  initial begin
    resetn = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    level = 8'h00;
    inv = 1'b0;
    timer_pwm_mode = 1'b1;
    wait_cyc(16);
    chk({26'h0, pwm_oe}, 32'h0);
    chk({31'h0, avs_waitrequest}, 32'h1);
    resetn <= 1'b1;
    @(posedge ref_clk);
    // table of trip and release cases
    for (int i = 0; i < 4; i++) begin
      level <= rows[i].idle;
      inv <= rows[i].mode;
      arm(rows[i].mode);
      chk({26'h0, pwm_oe}, 32'h3f);
      level <= rows[i].trip;
      wait_cyc(4);
      chk({26'h0, pwm_oe}, 32'h0);
      level <= rows[i].idle;
      wait_cyc(20);
      chk({26'h0, pwm_oe}, rows[i].rel ? 32'h3f : 32'h0);
    end
    // upper trip in two-stage, stop written once both are quiet
    level <= 8'h00;
    inv <= 1'b0;
    arm(1'b0);
    level <= 8'hff;
    wait_cyc(6);
    level <= 8'h00;
    wait_cyc(20);
    chk({26'h0, pwm_oe}, 32'h0);
    bus(1'b0, POC_OFS_STAT, 32'h0, rd);
    chk(rd, 32'h93); // hiz, upper, armed, pwm mode; no stop, nothing pending
    bus(1'b1, POC_OFS_TRIG, 32'h2, rd);
    wait_cyc(20);
    chk({26'h0, pwm_oe}, 32'h3f);
    // stop write in induced mode has no effect
    level <= 8'h80;
    inv <= 1'b1;
    arm(1'b1);
    level <= 8'hff;
    wait_cyc(4);
    bus(1'b1, POC_OFS_TRIG, 32'h2, rd);
    bus(1'b0, POC_OFS_STAT, 32'h0, rd);
    chk(rd & 32'h4, 32'h0);
    level <= 8'h80;
    wait_cyc(20);
    chk({26'h0, pwm_oe}, 32'h3f);
    // unarmed unit ignores a trip
    level <= 8'h00;
    inv <= 1'b0;
    bus(1'b1, POC_OFS_MODE, 32'h0, rd);
    level <= 8'hff;
    wait_cyc(4);
    chk({26'h0, pwm_oe}, 32'h3f);
    // timer outside pwm modes ignores a trip
    level <= 8'h00;
    arm(1'b0);
    timer_pwm_mode <= 1'b0;
    level <= 8'h80;
    wait_cyc(4);
    chk({26'h0, pwm_oe}, 32'h3f);
    timer_pwm_mode <= 1'b1;
    // register readback and unmapped place
    bus(1'b1, POC_OFS_MODE, 32'h1, rd);
    bus(1'b0, POC_OFS_MODE, 32'h0, rd);
    chk(rd, 32'h1);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk(rd, 32'h0);
    // pins copy the timer one cycle late
    @(posedge ref_clk);
    v = timer_pwm_in;
    @(posedge ref_clk);
    chk({26'h0, pwm_out}, {26'h0, v});
    // reset in mid-run during a cutoff: pins and bus back to reset values, unit disarmed
    arm(1'b0);
    level <= 8'hff;
    wait_cyc(4);
    chk({26'h0, pwm_oe}, 32'h0);
    resetn <= 1'b0;
    wait_cyc(2);
    chk({26'h0, pwm_oe}, 32'h0);
    chk({31'h0, avs_waitrequest}, 32'h1);
    resetn <= 1'b1;
    wait_cyc(6);
    chk({26'h0, pwm_oe}, 32'h3f); // comparator rise after reset ignored while unarmed
    bus(1'b0, POC_OFS_STAT, 32'h0, rd);
    chk(rd, 32'he0); // only levels and pwm mode set
    bus(1'b0, POC_OFS_MODE, 32'h0, rd);
    chk(rd, 32'h0); // two-stage after reset
    results();
  end
endmodule // pwm_overcurrent_cutoff_tb
